// ===== rtl/pin_ctl_pkg.sv
// Purpose: constants and types for the multifunction pin control block
// Assumes: register indices are word indices; byte address is index * 4
// Notes: control words are 14 bits, read back zero-extended to 32 bits
package pin_ctl_pkg;
	localparam int NUM_PINS = 5;
	localparam int IDX_W = 8;

	// register indices, byte address = 4 * index
	localparam logic [7:0] IDX_PIN1_CTRL = 8'h74;
	localparam logic [7:0] IDX_PIN2_CTRL = 8'h75;
	localparam logic [7:0] IDX_PIN3_CTRL = 8'h76;
	localparam logic [7:0] IDX_PIN4_CTRL = 8'h77;
	localparam logic [7:0] IDX_PIN5_CTRL = 8'h78;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h79;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h7a;
	localparam logic [7:0] IDX_PIN_LEVEL = 8'h7b;

	// function codes, bits 13:8 of a control word
	localparam logic [5:0] FN_GP_OUT = 6'h00;
	localparam logic [5:0] FN_BIT_CLOCK = 6'h01;
	localparam logic [5:0] FN_IRQ_OUT = 6'h02;
	localparam logic [5:0] FN_GP_IN = 6'h03;
	localparam logic [5:0] FN_BIAS_CURRENT = 6'h04;
	localparam logic [5:0] FN_BIAS_SHORT = 6'h05;
	localparam logic [5:0] FN_DMIC = 6'h06;
	localparam logic [5:0] FN_LOOP_LOCK = 6'h08;
	localparam logic [5:0] FN_LOOP_CLOCK = 6'h09;

	typedef struct packed {
		logic [5:0] function_select;
		logic direction;
		logic output_type;
		logic input_polarity;
		logic output_level;
		logic pulldown_enable;
		logic pullup_enable;
		logic irq_trigger_mode;
		logic debounce_enable;
	} pin_ctrl_s;

	localparam int CTRL_W = 14;

	// values after reset
	localparam logic [13:0] RST_PIN1_CTRL = 14'h00a8;
	localparam logic [13:0] RST_PIN2_CTRL = 14'h00a8;
	localparam logic [13:0] RST_PIN3_CTRL = 14'h00a8;
	localparam logic [13:0] RST_PIN4_CTRL = 14'h0220;
	localparam logic [13:0] RST_PIN5_CTRL = 14'h01a0;
	localparam logic [4:0] RST_IRQ_MASK = 5'h00;

	localparam int DEBOUNCE_CYCLES_DEFAULT = 16;
endpackage

// ===== rtl/multifunction_pin_control.sv
// Purpose: function select, pad control, debounce and interrupt status
//          for five multifunction pins, with an APB register slave
// Assumes: pins are asynchronous to clock and pass two flip-flops first
// Notes: zero wait states; read data is captured in the setup cycle
//
// Operation
// - bits 13:8 pick general output, irq out, general input, bias flags or loop lock/clock.
// - code 06h on pin 1 drives the digital mic channel clock out.
// - code 06h on pin 2 takes the pin as the digital mic serial input.
// - codes 01h on pins 1-3 and 06h, 07h on pin 3 are reserved; pins 1-3 reset to code 00h.
// - bit 4 sets the pin level only under the general output code, reset 0.
// - bit 3 enables the weak pull-down, reset 1 on pins 1 to 3.
// - bit 2 enables the weak pull-up, reset 0.
// - bit 0 routes the input through the debounce filter, reset 0.
// - pin 5 resets to the bit clock code 1h and may then be input or output.
// - while pin 5 is bit clock its other control fields have no effect, save bits 5 and 0 on its pin level bit.
// - with pin 5 not bit clock the master clock serves as bit clock.
// - pin 4 resets as the interrupt request output.
// - bit 6 selects push-pull or open-drain, where a 1 only releases the pin.
// - bit 5 sets input polarity and bit 1 picks level or both-edge interrupts.
// - with pull-up and pull-down both set neither resistor is enabled.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module multifunction_pin_control
	import pin_ctl_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYCLES_DEFAULT
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [4:0] pin_in,
	output logic [4:0] pin_out,
	output logic [4:0] pin_oe_n,
	output logic [4:0] pullup_on,
	output logic [4:0] pulldown_on,
	input wire logic bias_current_detect,
	input wire logic bias_short_detect,
	input wire logic loop_lock,
	input wire logic loop_clock,
	input wire logic digital_mic_channel_clock,
	input wire logic bit_clock_drive,
	input wire logic bit_clock_drive_en,
	input wire logic master_clock,
	output logic bit_clock,
	output logic digital_mic_serial_input,
	output logic irq
);
	localparam int CNT_W = $clog2(DEBOUNCE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEBOUNCE_CYCLES - 1);

	function automatic logic is_ctrl(input logic [7:0] idx);
		is_ctrl = (idx >= IDX_PIN1_CTRL) && (idx <= IDX_PIN5_CTRL);
	endfunction

	pin_ctrl_s ctrl_q [NUM_PINS];
	logic [4:0] status_q;
	logic [4:0] mask_q;
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic [4:0] filt_q;
	logic [4:0] prev_q;
	logic [CNT_W-1:0] cnt_q [NUM_PINS];
	logic [1:0] mclk_sync_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic bit_clock_q;
	logic irq_q;
	logic dmic_q;
	logic [4:0] pin_out_q;
	logic [4:0] pin_oe_n_q;
	logic [4:0] pullup_q;
	logic [4:0] pulldown_q;

	// bus decode
	wire logic [7:0] bus_idx = paddr[9:2];
	wire logic addr_hi_zero = (paddr[31:10] == '0) && (paddr[1:0] == 2'b00);
	wire logic setup = psel && !penable;
	wire logic access = psel && penable;
	wire logic wr_en = access && pwrite;
	wire logic rd_en = access && !pwrite;
	wire logic hit_ctrl = addr_hi_zero && is_ctrl(bus_idx);
	wire logic hit_status = addr_hi_zero && (bus_idx == IDX_IRQ_STATUS);
	wire logic hit_mask = addr_hi_zero && (bus_idx == IDX_IRQ_MASK);
	wire logic hit_level = addr_hi_zero && (bus_idx == IDX_PIN_LEVEL);
	wire logic hit_any = hit_ctrl || hit_status || hit_mask || hit_level;
	wire logic [2:0] ctrl_sel = 3'(bus_idx - IDX_PIN1_CTRL);
	wire logic status_clear = rd_en && hit_status;

	// per-pin combinational view
	logic [4:0] raw_in;
	logic [4:0] sel_in;
	logic [4:0] asserted;
	logic [4:0] irq_set;
	logic [4:0] drv_val;
	logic [4:0] drv_on;
	logic [4:0] pu_d;
	logic [4:0] pd_d;
	logic [4:0] out_d;
	logic [4:0] oe_n_d;
	logic [31:0] rd_mux;
	logic [5:0] fn;
	logic bclk_mode;
	logic irq_d;

	assign raw_in = sync2_q;
	assign bclk_mode = ctrl_q[4].function_select == FN_BIT_CLOCK;
	assign irq_d = |(status_q & mask_q);

	always_comb
	begin
		sel_in = '0;
		asserted = '0;
		irq_set = '0;
		drv_val = '0;
		drv_on = '0;
		pu_d = '0;
		pd_d = '0;
		out_d = '0;
		oe_n_d = '1;
		fn = '0;
		for (int i = 0; i < NUM_PINS; i++)
		begin
			fn = ctrl_q[i].function_select;
			sel_in[i] = ctrl_q[i].debounce_enable ? filt_q[i] : raw_in[i];
			asserted[i] = ctrl_q[i].input_polarity ? sel_in[i] : !sel_in[i];
			unique case (fn)
				FN_GP_OUT:
				begin
					drv_val[i] = ctrl_q[i].output_level;
					drv_on[i] = 1'b1;
				end
				FN_IRQ_OUT:
				begin
					drv_val[i] = irq_q;
					drv_on[i] = 1'b1;
				end
				FN_BIAS_CURRENT:
				begin
					drv_val[i] = bias_current_detect;
					drv_on[i] = 1'b1;
				end
				FN_BIAS_SHORT:
				begin
					drv_val[i] = bias_short_detect;
					drv_on[i] = 1'b1;
				end
				FN_LOOP_LOCK:
				begin
					drv_val[i] = loop_lock;
					drv_on[i] = 1'b1;
				end
				FN_LOOP_CLOCK:
				begin
					drv_val[i] = loop_clock;
					drv_on[i] = 1'b1;
				end
				// mic channel clock on pin 1
				FN_DMIC:
				begin
					drv_val[i] = digital_mic_channel_clock;
					drv_on[i] = (i == 0);
				end
				default:
				begin
					// reserved codes and inputs leave the pad undriven
					drv_val[i] = 1'b0;
					drv_on[i] = 1'b0;
				end
			endcase
			if (fn == FN_GP_IN)
			begin
				if (ctrl_q[i].irq_trigger_mode)
					irq_set[i] = sel_in[i] != prev_q[i];
				else
					irq_set[i] = asserted[i];
			end
			pu_d[i] = ctrl_q[i].pullup_enable && !ctrl_q[i].pulldown_enable;
			pd_d[i] = ctrl_q[i].pulldown_enable && !ctrl_q[i].pullup_enable;
			out_d[i] = ctrl_q[i].output_type ? 1'b0 : drv_val[i];
			oe_n_d[i] = !(drv_on[i] && !ctrl_q[i].direction &&
				!(ctrl_q[i].output_type && drv_val[i]));
		end
		if (bclk_mode)
		begin
			irq_set[4] = 1'b0;
			pu_d[4] = 1'b0;
			pd_d[4] = 1'b0;
			out_d[4] = bit_clock_drive;
			oe_n_d[4] = !bit_clock_drive_en;
		end
	end

	always_comb
	begin
		rd_mux = '0;
		if (hit_ctrl)
			rd_mux = 32'(ctrl_q[ctrl_sel]);
		else if (hit_status)
			rd_mux = 32'(status_q);
		else if (hit_mask)
			rd_mux = 32'(mask_q);
		else if (hit_level)
			rd_mux = 32'(asserted);
	end

	// register bank
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ctrl_q[0] <= RST_PIN1_CTRL;
			ctrl_q[1] <= RST_PIN2_CTRL;
			ctrl_q[2] <= RST_PIN3_CTRL;
			ctrl_q[3] <= RST_PIN4_CTRL;
			ctrl_q[4] <= RST_PIN5_CTRL;
			mask_q <= RST_IRQ_MASK;
		end
		else if (wr_en)
		begin
			if (hit_ctrl)
				ctrl_q[ctrl_sel] <= pwdata[CTRL_W-1:0];
			if (hit_mask)
				mask_q <= pwdata[4:0];
		end
	end

	// status: read clears only the bits the reader was shown at setup,
	// so an event landing between setup and access is not lost
	always_ff @(posedge clock)
	begin
		if (rst)
			status_q <= '0;
		else
			status_q <= (status_q & ~({5{status_clear}} & prdata_q[4:0])) | irq_set;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end
		else if (setup)
		begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_q <= !hit_any;
		end
	end

	// input synchronisers; first stage feeds only the second
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			mclk_sync_q <= '0;
		end
		else
		begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			mclk_sync_q <= {mclk_sync_q[0], master_clock};
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			filt_q <= '0;
			for (int i = 0; i < NUM_PINS; i++)
				cnt_q[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_PINS; i++)
			begin
				if (raw_in[i] == filt_q[i])
					cnt_q[i] <= '0;
				else if (cnt_q[i] == CNT_LAST)
				begin
					filt_q[i] <= raw_in[i];
					cnt_q[i] <= '0;
				end
				else
					cnt_q[i] <= cnt_q[i] + 1'b1;
			end
		end
	end

	// pad and side outputs, registered to keep glitches off the pins
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			prev_q <= '0;
			pin_out_q <= '0;
			pin_oe_n_q <= '1;
			pullup_q <= '0;
			pulldown_q <= '0;
			bit_clock_q <= 1'b0;
			dmic_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			prev_q <= sel_in;
			pin_out_q <= out_d;
			pin_oe_n_q <= oe_n_d;
			pullup_q <= pu_d;
			pulldown_q <= pd_d;
			irq_q <= irq_d;
			bit_clock_q <= bclk_mode ? raw_in[4] : mclk_sync_q[1];
			dmic_q <= (ctrl_q[1].function_select == FN_DMIC) ? raw_in[1] : 1'b0;
		end
	end

	// direction is software's duty; bit 7 only gates the driver
	assign pin_out = pin_out_q;
	assign pin_oe_n = pin_oe_n_q;
	assign pullup_on = pullup_q;
	assign pulldown_on = pulldown_q;
	assign bit_clock = bit_clock_q;
	assign digital_mic_serial_input = dmic_q;
	assign irq = irq_q;
	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = pslverr_q && access;
endmodule // multifunction_pin_control

`default_nettype wire

// ===== verification/pin_pads.sv
// Purpose: pads and outside circuitry on the five pins
// Assumes: ext_en marks a pin driven from outside the device
// Notes: a floating pad with no pull toggles each cycle
`timescale 1ns/100ps
`default_nettype none
module pin_pads
(
	input wire logic clock,
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe_n,
	input wire logic [4:0] pullup_on,
	input wire logic [4:0] pulldown_on,
	input wire logic [4:0] ext_en,
	input wire logic [4:0] ext_val,
	output logic [4:0] pin_in
);
	logic [4:0] float_q = 5'h0a;
	always_ff @(posedge clock)
		float_q <= ~float_q;
	always_comb
		for (int i = 0; i < 5; i++)
			if (!pin_oe_n[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pullup_on[i])
				pin_in[i] = 1'b1;
			else if (pulldown_on[i])
				pin_in[i] = 1'b0;
			else
				pin_in[i] = float_q[i];
endmodule // pin_pads
`default_nettype wire

// ===== verification/pin_ctl_asserts.sv
// Purpose: port assertions for multifunction_pin_control
// Assumes: zero wait APB, two-flop input syncs
// Notes: bit clock check waits for the syncs to fill
`timescale 1ns/100ps
`default_nettype none
module pin_ctl_asserts
(
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [4:0] pin_in,
	input wire logic [4:0] pin_oe_n,
	input wire logic [4:0] pullup_on,
	input wire logic [4:0] pulldown_on,
	input wire logic master_clock,
	input wire logic bit_clock,
	input wire logic digital_mic_serial_input,
	input wire logic irq
);
	logic [1:0] age_q;
	logic [1:0] age_d;
	assign age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
	always_ff @(posedge clock)
		if (rst)
			age_q <= 2'h0;
		else
			age_q <= age_d;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_reset_end;
		$fell(rst);
	endsequence
	sequence s_clocks_agree;
		($stable(pin_in[4]) && $stable(master_clock)
			&& pin_in[4] == master_clock) [*4];
	endsequence
	a_reset_pulls: assert property (
		s_reset_end |=> pulldown_on == 5'h07 && pullup_on == 5'h00
		&& pin_oe_n[2:0] == 3'h7)
		else $error("pad state after reset wrong");
	a_pin4_irq_out: assert property (
		s_reset_end |-> ##2 !pin_oe_n[3])
		else $error("pin 4 not driving after reset");
	a_pulls_exclusive: assert property (
		(pullup_on & pulldown_on) == 5'h00)
		else $error("both pulls on");
	a_unmapped_err: assert property (
		s_access ##0 (paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0)
		else $error("misaligned access not refused");
	a_mapped_ok: assert property (
		s_access ##0 (paddr == 32'h0000_01d0)
		|-> !pslverr && prdata[31:14] == 18'h0)
		else $error("pin 1 control access wrong");
	a_dmic_in: assert property (
		(!pin_in[1]) [*4] |-> !digital_mic_serial_input)
		else $error("mic data high from a low pad");
	a_bclk_source: assert property (
		age_q == 2'h3 ##0 s_clocks_agree |-> bit_clock == master_clock)
		else $error("bit clock differs from both sources");
	a_irq_quiet: assert property (
		s_reset_end |-> (!irq) [*3])
		else $error("irq high with mask cleared");
endmodule // pin_ctl_asserts
`default_nettype wire

// ===== verification/tb.sv
// Purpose: self-checking bench for multifunction_pin_control
// Assumes: APB master here, pads modelled by pin_pads
// Notes: short debounce count keeps pulse tests brief
`timescale 1ns/100ps
`default_nettype none
module tb;
	import pin_ctl_pkg::*;
	localparam int DB = 4;
	logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, mic = 0;
	logic bdrv = 0, bdrv_en = 0, mclk = 0, pready, pslverr, bclk, dmi, irq;
	logic [31:0] paddr = 0, pwdata = 0, prdata, r;
	logic [3:0] src = 0;
	logic [4:0] ext_en = 0, ext_val = 0, pin_in, pin_out, oe_n, pu, pd;
	logic [31:0] q[$];
	int bad_count = 0, n_tests = 0;
	logic [31:0] gw[5] = '{32'h0000_0010, 32'h0000_0000, 32'h0000_0050,
		32'h0000_0040, 32'h0000_0410};
	logic [1:0] ge[5] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h0};
	logic [5:0] fc[4] = '{FN_BIAS_CURRENT, FN_BIAS_SHORT, FN_LOOP_LOCK,
		FN_LOOP_CLOCK};
	logic [31:0] pw[3] = '{32'h0000_008c, 32'h0000_0084, 32'h0000_0088};
	logic [1:0] pe[3] = '{2'h0, 2'h2, 2'h1};
	multifunction_pin_control #(.DEBOUNCE_CYCLES(DB)) u_dut (
		.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(oe_n), .pullup_on(pu),
		.pulldown_on(pd), .bias_current_detect(src[3]),
		.bias_short_detect(src[2]), .loop_lock(src[1]), .loop_clock(src[0]),
		.digital_mic_channel_clock(mic), .bit_clock_drive(bdrv),
		.bit_clock_drive_en(bdrv_en), .master_clock(mclk),
		.bit_clock(bclk), .digital_mic_serial_input(dmi), .irq(irq));
	pin_pads u_pads (.clock(clock), .pin_out(pin_out), .pin_oe_n(oe_n),
		.pullup_on(pu), .pulldown_on(pd), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));
	initial
		forever #10 clock = ~clock;
	task automatic check(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic results();
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [31:0] a, d, e);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			q.push_back(e);
		@(posedge clock);
		penable <= 1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		apb(1, {22'h0, i, 2'h0}, d, 32'h0);
	endtask
	task automatic rd(input logic [7:0] i, input logic [13:0] e);
		apb(0, {22'h0, i, 2'h0}, 32'h0, {18'h0, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// read data is judged at the access edge, oldest note first
	always @(posedge clock)
		if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
			check("prdata", prdata, q.pop_front());
	initial
	begin
		#100us;
		bad_count++;
		results();
	end
	initial
	begin
		void'($urandom(45189));
		repeat (5) @(posedge clock);
		rst <= 0;
		rd(IDX_PIN1_CTRL, RST_PIN1_CTRL);
		rd(IDX_PIN2_CTRL, RST_PIN2_CTRL);
		rd(IDX_PIN3_CTRL, RST_PIN3_CTRL);
		rd(IDX_PIN4_CTRL, RST_PIN4_CTRL);
		rd(IDX_PIN5_CTRL, RST_PIN5_CTRL);
		rd(IDX_IRQ_MASK, {9'h0, RST_IRQ_MASK});
		apb(0, 32'h0000_01fc, 32'h0, 32'h0);
		apb(0, 32'h0000_01d1, 32'h0, 32'h0);
		r = $urandom & 32'h0000_00ff;
		wr(IDX_PIN1_CTRL, r);
		rd(IDX_PIN1_CTRL, r[13:0]);
		foreach (gw[k])
		begin
			wr(IDX_PIN1_CTRL, gw[k]);
			cyc(2);
			check("pin1 pad", 32'({pin_out[0], oe_n[0]}), 32'(ge[k]));
		end
		repeat (2)
		begin
			@(posedge clock);
			src <= 4'($urandom);
			foreach (fc[k])
			begin
				wr(IDX_PIN3_CTRL, {18'h0, fc[k], 8'h00});
				cyc(3);
				check("pin3 function", 32'(pin_out[2]), 32'(src[3 - k]));
			end
		end
		wr(IDX_PIN3_CTRL, 32'h0000_0610);
		cyc(2);
		check("pin3 reserved", 32'(oe_n[2]), 32'h1);
		foreach (pw[k])
		begin
			wr(IDX_PIN3_CTRL, pw[k]);
			cyc(2);
			check("pin3 pulls", 32'({pu[2], pd[2]}), 32'(pe[k]));
		end
		wr(IDX_PIN1_CTRL, 32'h0000_0600);
		wr(IDX_PIN2_CTRL, 32'h0000_0680);
		for (int v = 0; v < 2; v++)
		begin
			@(posedge clock);
			mic <= v[0];
			ext_en <= 5'h02;
			ext_val <= {3'h0, v[0], 1'b0};
			cyc(5);
			check("mic clock", 32'(pin_out[0]), 32'(v[0]));
			check("mic data", 32'(dmi), 32'(v[0]));
		end
		for (int v = 0; v < 2; v++)
		begin
			@(posedge clock);
			ext_en <= 5'h10;
			ext_val <= {v[0], 4'h0};
			mclk <= !v[0];
			cyc(5);
			check("bit clock in", 32'(bclk), 32'(v[0]));
		end
		wr(IDX_PIN5_CTRL, 32'h0000_0114);
		bdrv_en <= 1;
		bdrv <= 1;
		ext_en <= 5'h00;
		cyc(3);
		check("bit clock out", 32'({pu[4], oe_n[4], pin_out[4]}), 32'h1);
		wr(IDX_PIN5_CTRL, 32'h0000_00a0);
		bdrv_en <= 0;
		ext_en <= 5'h10;
		for (int v = 1; v >= 0; v--)
		begin
			@(posedge clock);
			mclk <= v[0];
			cyc(5);
			check("master as bit clock", 32'(bclk), 32'(v[0]));
		end
		wr(IDX_IRQ_MASK, 32'h0000_0001);
		// park pin 1 as a plain input and let the pad settle low before
		// it becomes an interrupt source, so no stale level is latched
		wr(IDX_PIN1_CTRL, 32'h0000_00a0);
		ext_en <= 5'h11;
		ext_val <= 5'h00;
		cyc(4);
		for (int d = 0; d < 2; d++)
		begin
			wr(IDX_PIN1_CTRL, 32'h0000_03a0 | 32'(d));
			ext_en <= 5'h11;
			ext_val <= 5'h00;
			cyc(DB + 4);
			rd(IDX_IRQ_STATUS, 14'h0);
			ext_val <= 5'h01;
			@(posedge clock);
			ext_val <= 5'h00;
			cyc(DB + 6);
			rd(IDX_IRQ_STATUS, d ? 14'h0 : 14'h1);
		end
		ext_val <= 5'h01;
		cyc(DB + 6);
		check("irq", 32'(irq), 32'h1);
		wr(IDX_IRQ_MASK, 32'h0);
		cyc(2);
		check("irq masked", 32'(irq), 32'h0);
		@(posedge clock);
		ext_val <= 5'h00;
		cyc(DB + 6);
		rd(IDX_IRQ_STATUS, 14'h1);
		rd(IDX_IRQ_STATUS, 14'h0);
		wr(IDX_PIN1_CTRL, 32'h0000_03a2);
		cyc(5);
		rd(IDX_IRQ_STATUS, 14'h0);
		for (int v = 1; v >= 0; v--)
		begin
			@(posedge clock);
			ext_val <= {4'h0, v[0]};
			cyc(6);
			rd(IDX_IRQ_STATUS, 14'h1);
		end
		results();
	end
endmodule // tb
bind multifunction_pin_control pin_ctl_asserts u_chk (.clock(clock),
	.rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pslverr(pslverr), .pin_in(pin_in),
	.pin_oe_n(pin_oe_n), .pullup_on(pullup_on), .pulldown_on(pulldown_on),
	.master_clock(master_clock), .bit_clock(bit_clock),
	.digital_mic_serial_input(digital_mic_serial_input), .irq(irq));
`default_nettype wire
